// ### core/bbsx_pkg.sv
// Package: constants, types and carriers of the branch and bit-set unit
package bbsx_pkg;

   // Opcode patterns
   localparam logic [7:0] OPC_BR_NO_OVERFLOW = 8'hE5;
   localparam logic [7:0] OPC_BR_NONZERO = 8'hE1;
   localparam logic [4:0] OPC_BR_ALWAYS = 5'h1A;
   localparam logic [3:0] OPC_SET_FILE_BIT = 4'h8;

   // Instruction field positions
   localparam int OPC8_MSB = 15;
   localparam int OPC8_LSB = 8;
   localparam int OPC5_LSB = 11;
   localparam int OPC4_LSB = 12;
   localparam int BIT_MSB = 11;
   localparam int BIT_LSB = 9;
   localparam int BANKSEL_POS = 8;
   localparam int FADR_MSB = 7;
   localparam int OFF8_MSB = 7;
   localparam int OFF11_MSB = 10;

   // Addressing constants
   localparam logic [7:0] ILO_LIMIT = 8'h5F;
   localparam logic [7:0] ACC_SPLIT = 8'h60;
   localparam logic [3:0] ACC_HIGH_BANK = 4'hF;
   localparam logic [3:0] ACC_LOW_BANK = 4'h0;

   // Quarter phases of one instruction cycle
   localparam logic [1:0] Q1 = 2'h0;
   localparam logic [1:0] Q2 = 2'h1;
   localparam logic [1:0] Q3 = 2'h2;
   localparam logic [1:0] Q4 = 2'h3;

   // Register offsets (byte addresses)
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_BANK = 8'h04;
   localparam logic [7:0] OFS_IDXBASE = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0C;
   localparam logic [7:0] OFS_LASTPC = 8'h10;

   // Field positions and reset values
   localparam int CTRL_EXT_POS = 0;
   localparam logic RST_EXT = 1'b0;
   localparam logic [3:0] RST_BANK = 4'h0;
   localparam logic [11:0] RST_IDXBASE = 12'h000;
   localparam logic [20:0] RST_PC = 21'h00_0000;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_EXEC = 2'b01,
      ST_FLUSH = 2'b11
   } bbsx_state_t;

   typedef enum logic [2:0] {
      OP_NONE = 3'h0,
      OP_BR_NO_OVERFLOW = 3'h1,
      OP_BR_NONZERO = 3'h2,
      OP_BR_ALWAYS = 3'h3,
      OP_SET_FILE_BIT = 3'h4
   } bbsx_op_t;

   typedef struct packed {
      logic neg;
      logic ov;
      logic zero;
      logic dc;
      logic carry;
   } bbsx_flags_t;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } bbsx_wb_req_t;

   typedef struct packed {
      logic rd;
      logic wr;
      logic [11:0] addr;
      logic [7:0] wdata;
   } bbsx_mem_req_t;

   typedef struct packed {
      logic wr;
      logic [20:0] target;
   } bbsx_pc_req_t;

endpackage : bbsx_pkg

// ### core/bbsx_agu.sv
// File-register address unit for the bit-set instruction
`timescale 1ns/1ps
`default_nettype none
module bbsx_agu
(
   input wire logic bank_sel,
   input wire logic [7:0] fadr,
   input wire logic ext_en,
   input wire logic [3:0] bank,
   input wire logic [11:0] idx_base,
   output logic [11:0] addr
);
   import bbsx_pkg::*;

   // Bank, access bank or indexed literal offset
   always_comb
   begin
      if (bank_sel)
      begin
         addr = {bank, fadr};
      end
      else if (ext_en && (fadr <= ILO_LIMIT))
      begin
         addr = idx_base + {4'h0, fadr};
      end
      else if (fadr < ACC_SPLIT)
      begin
         addr = {ACC_LOW_BANK, fadr};
      end
      else
      begin
         addr = {ACC_HIGH_BANK, fadr};
      end
   end

endmodule : bbsx_agu
`default_nettype wire

// ### core/bbsx_exec.sv
// Decode and execute of relative branches and bit set, with Wishbone regs
//
// Summary of operation
// - Opcode E5 with 8-bit offset branches only when overflow is clear.
// - Conditional target is incremented PC plus twice the signed offset.
// - Untaken branch takes one cycle; taken writes PC in Q4, then a nop.
// - Opcode E1 branches only when zero flag is clear, same timing.
// - Prefix 11010 with 11-bit offset always loads incremented PC plus 2n.
// - Unconditional branch always takes two cycles, second being a nop.
// - Bit set: read file register, set one bit, write back in one cycle.
// - Bank bit 0 picks the access bank; 1 uses the bank select register.
// - Extended set with bank bit zero uses indexed offset for f up to 5Fh.
`timescale 1ns/1ps
`default_nettype none
module bbsx_exec
(
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic instr_valid,
   input wire logic [15:0] instr,
   input wire logic [20:0] pc_incr,
   input wire bbsx_pkg::bbsx_flags_t flags,
   input wire logic [7:0] mem_rdata,
   input wire bbsx_pkg::bbsx_wb_req_t wb_req,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output bbsx_pkg::bbsx_mem_req_t mem_req,
   output bbsx_pkg::bbsx_pc_req_t pc_req,
   output logic fetch_ready,
   output logic [1:0] qphase
);
   import bbsx_pkg::*;

   typedef struct packed {
      bbsx_state_t st;
      logic [1:0] q;
      bbsx_op_t op;
      logic take;
      logic [2:0] bitn;
      logic [20:0] target;
      logic [20:0] last_pc;
      logic [7:0] rdata;
      bbsx_mem_req_t mem;
      bbsx_pc_req_t pc;
      logic fetch_ready;
      logic ext_en;
      logic [3:0] bank;
      logic [11:0] idx_base;
      logic wb_ack;
      logic [31:0] wb_dat;
   } bbsx_regs_t;

   bbsx_regs_t r_reg;
   bbsx_regs_t r_next;
   bbsx_op_t dec_op;
   logic [11:0] agu_addr;
   logic [20:0] off8_bytes;
   logic [20:0] off11_bytes;
   logic wb_hit;

   // Address for the file register, from the word being decoded
   bbsx_agu u_agu (
      .bank_sel(instr[BANKSEL_POS]),
      .fadr(instr[FADR_MSB:0]),
      .ext_en(r_reg.ext_en),
      .bank(r_reg.bank),
      .idx_base(r_reg.idx_base),
      .addr(agu_addr)
   );

   // Opcode classification; anything else is left to other decoders
   always_comb
   begin
      if (instr[OPC8_MSB:OPC8_LSB] == OPC_BR_NO_OVERFLOW)
      begin
         dec_op = OP_BR_NO_OVERFLOW;
      end
      else if (instr[OPC8_MSB:OPC8_LSB] == OPC_BR_NONZERO)
      begin
         dec_op = OP_BR_NONZERO;
      end
      else if (instr[OPC8_MSB:OPC5_LSB] == OPC_BR_ALWAYS)
      begin
         dec_op = OP_BR_ALWAYS;
      end
      else if (instr[OPC8_MSB:OPC4_LSB] == OPC_SET_FILE_BIT)
      begin
         dec_op = OP_SET_FILE_BIT;
      end
      else
      begin
         dec_op = OP_NONE;
      end
   end

   // Sign-extended offsets already doubled into byte distances
   assign off8_bytes = {{12{instr[OFF8_MSB]}}, instr[OFF8_MSB:0], 1'b0};
   assign off11_bytes = {{9{instr[OFF11_MSB]}}, instr[OFF11_MSB:0], 1'b0};
   assign wb_hit = wb_req.cyc && wb_req.stb && !r_reg.wb_ack;

   // Next-state logic: sequencer, execution and register slave
   always_comb
   begin
      r_next = r_reg;
      r_next.q = r_reg.q + 2'h1;
      r_next.pc.wr = 1'b0;
      r_next.mem.wr = 1'b0;
      r_next.wb_ack = 1'b0;
      case (r_reg.q)
         Q1:
         begin
            if (r_reg.st == ST_IDLE && instr_valid)
            begin
               // Decode; the target is fixed now so a later PC change is moot
               r_next.op = dec_op;
               r_next.st = ST_EXEC;
               r_next.bitn = instr[BIT_MSB:BIT_LSB];
               r_next.take = 1'b0;
               r_next.target = pc_incr;
               case (dec_op)
                  OP_BR_NO_OVERFLOW:
                  begin
                     r_next.take = !flags.ov;
                     r_next.target = pc_incr + off8_bytes;
                  end
                  OP_BR_NONZERO:
                  begin
                     r_next.take = !flags.zero;
                     r_next.target = pc_incr + off8_bytes;
                  end
                  OP_BR_ALWAYS:
                  begin
                     r_next.take = 1'b1;
                     r_next.target = pc_incr + off11_bytes;
                  end
                  OP_SET_FILE_BIT:
                  begin
                     r_next.mem.rd = 1'b1;
                     r_next.mem.addr = agu_addr;
                  end
                  default:
                  begin
                     r_next.take = 1'b0;
                  end
               endcase
            end
         end
         Q2:
         begin
            // Read of file register completes at the end of Q2
            if (r_reg.st == ST_EXEC && r_reg.op == OP_SET_FILE_BIT)
            begin
               r_next.rdata = mem_rdata;
               r_next.mem.rd = 1'b0;
            end
         end
         Q3:
         begin
            // Process; writes land during Q4
            if (r_reg.st == ST_EXEC && r_reg.op == OP_SET_FILE_BIT)
            begin
               r_next.mem.wr = 1'b1;
               r_next.mem.wdata = r_reg.rdata | (8'h01 << r_reg.bitn);
            end
            if (r_reg.st == ST_EXEC && r_reg.take)
            begin
               r_next.pc.wr = 1'b1;
               r_next.pc.target = r_reg.target;
               r_next.last_pc = r_reg.target;
            end
            if (r_reg.st == ST_EXEC && r_reg.take)
            begin
               r_next.fetch_ready = 1'b0; // Next word is stale, flush it
            end
         end
         default:
         begin
            // End of Q4: a taken branch spends the next cycle as a nop
            if (r_reg.st == ST_EXEC && r_reg.take)
            begin
               r_next.st = ST_FLUSH;
            end
            else
            begin
               r_next.st = ST_IDLE;
               r_next.fetch_ready = 1'b1;
            end
            r_next.take = 1'b0;
         end
      endcase
      // No flag write path exists: status passes through untouched

      // Wishbone slave: one-cycle answer, unmapped reads return zero
      if (wb_hit)
      begin
         r_next.wb_ack = 1'b1;
         r_next.wb_dat = 32'h0000_0000;
         if (wb_req.adr == OFS_CTRL)
         begin
            r_next.wb_dat[CTRL_EXT_POS] = r_reg.ext_en;
            if (wb_req.we && wb_req.sel[0])
            begin
               r_next.ext_en = wb_req.dat[CTRL_EXT_POS];
            end
         end
         else if (wb_req.adr == OFS_BANK)
         begin
            r_next.wb_dat[3:0] = r_reg.bank;
            if (wb_req.we && wb_req.sel[0])
            begin
               r_next.bank = wb_req.dat[3:0];
            end
         end
         else if (wb_req.adr == OFS_IDXBASE)
         begin
            r_next.wb_dat[11:0] = r_reg.idx_base;
            if (wb_req.we && wb_req.sel[0])
            begin
               r_next.idx_base[7:0] = wb_req.dat[7:0];
            end
            if (wb_req.we && wb_req.sel[1])
            begin
               r_next.idx_base[11:8] = wb_req.dat[11:8];
            end
         end
         else if (wb_req.adr == OFS_STATUS)
         begin
            r_next.wb_dat[7:0] = {r_reg.op, r_reg.st, r_reg.q, r_reg.take};
         end
         else if (wb_req.adr == OFS_LASTPC)
         begin
            r_next.wb_dat[20:0] = r_reg.last_pc;
         end
         else
         begin
            r_next.wb_dat = 32'h0000_0000;
         end
      end
      // Data only matters with ack; clear it so idle reads are quiet
      if (!wb_hit)
      begin
         r_next.wb_dat = 32'h0000_0000;
      end
   end

   // State register; clock enable freezes everything including the bus
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         r_reg <= '0;
         r_reg.st <= ST_IDLE;
         r_reg.op <= OP_NONE;
         r_reg.fetch_ready <= 1'b1;
         r_reg.ext_en <= RST_EXT;
         r_reg.bank <= RST_BANK;
         r_reg.idx_base <= RST_IDXBASE;
         r_reg.target <= RST_PC;
         r_reg.last_pc <= RST_PC;
      end
      else if (ce)
      begin
         r_reg <= r_next;
      end
   end

   // Outputs straight from the state register
   assign wb_dat_o = r_reg.wb_dat;
   assign wb_ack_o = r_reg.wb_ack;
   assign mem_req = r_reg.mem;
   assign pc_req = r_reg.pc;
   assign fetch_ready = r_reg.fetch_ready;
   assign qphase = r_reg.q;

endmodule : bbsx_exec
`default_nettype wire

// ### tb/bbsx_exec_assertions.sv
// Port checker of the branch and bit-set unit, bound to its top
`timescale 1ns/1ps
`default_nettype none
module bbsx_exec_chk
(
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [7:0] mem_rdata,
   input wire bbsx_pkg::bbsx_wb_req_t wb_req,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire bbsx_pkg::bbsx_mem_req_t mem_req,
   input wire bbsx_pkg::bbsx_pc_req_t pc_req,
   input wire logic fetch_ready,
   input wire logic [1:0] qphase
);
   import bbsx_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // Bit set steps: read in Q2, idle Q3, write back in Q4
   sequence s_rd;
      mem_req.rd && qphase == Q2;
   endsequence
   sequence s_wr;
      mem_req.wr && qphase == Q4;
   endsequence
   property p_bitset;
      mem_req.rd |-> s_rd ##1 !mem_req.rd ##1 s_wr;
   endproperty
   a_bitset: assert property (p_bitset)
      else $error("bit set steps");
   property p_addr_held;
      mem_req.wr |-> mem_req.addr == $past(mem_req.addr, 2);
   endproperty
   a_addr_held: assert property (p_addr_held)
      else $error("addr moved");
   // Written byte keeps every read bit and adds at most one
   property p_wdata;
      mem_req.wr |-> ($past(mem_rdata, 2) & ~mem_req.wdata) == 8'h00 &&
         $countones(mem_req.wdata ^ $past(mem_rdata, 2)) <= 1;
   endproperty
   a_wdata: assert property (p_wdata) else $error("bad write data");
   property p_pcwr_q4;
      pc_req.wr |-> qphase == Q4 && !mem_req.wr;
   endproperty
   a_pcwr_q4: assert property (p_pcwr_q4)
      else $error("pc write phase");
   // A taken branch is followed by a whole nop cycle
   property p_flush;
      pc_req.wr |-> (!fetch_ready && !mem_req.rd) [*5] ##1 !pc_req.wr [*3];
   endproperty
   a_flush: assert property (p_flush) else $error("no flush cycle");
   property p_ack_lat;
      wb_req.cyc && wb_req.stb && !wb_ack_o && ce |=> wb_ack_o;
   endproperty
   a_ack_lat: assert property (p_ack_lat) else $error("ack late");
   property p_ack_one;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_one: assert property (p_ack_one) else $error("ack too long");
   property p_dat_zero;
      !wb_ack_o |-> wb_dat_o == 32'h0000_0000;
   endproperty
   a_dat_zero: assert property (p_dat_zero) else $error("stray read data");
endmodule : bbsx_exec_chk
bind bbsx_exec bbsx_exec_chk i_chk (.clk(clk), .rst(rst), .ce(ce),
   .mem_rdata(mem_rdata), .wb_req(wb_req), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .mem_req(mem_req), .pc_req(pc_req),
   .fetch_ready(fetch_ready), .qphase(qphase));
`default_nettype wire

// ### tb/tb_branch_and_bit_set_exec.sv
// Self-checking bench of the branch and bit-set unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
   begin n_tests++; if ((g) !== (e)) begin bad_count++; \
   $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e); end end
module tb_branch_and_bit_set_exec;
   import bbsx_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic instr_valid = 1'b0;
   logic [15:0] instr = 16'h0000;
   logic [20:0] pc_incr = 21'h00_1000;
   bbsx_flags_t flags = '0;
   logic [7:0] mem_rdata = 8'h00;
   bbsx_wb_req_t wb_req = '0;
   logic [31:0] wb_dat_o;
   logic wb_ack_o;
   bbsx_mem_req_t mem_req;
   bbsx_pc_req_t pc_req;
   logic fetch_ready;
   logic [1:0] qphase;
   int bad_count = 0;
   int n_tests = 0;
   logic [31:0] rd;
   logic pw;
   logic mw;
   logic [1:0] q0;
   // 40 MHz clock
   always #12.5 clk = ~clk;
   bbsx_exec i_dut (.clk(clk), .rst(rst), .ce(ce), .instr_valid(instr_valid),
      .instr(instr), .pc_incr(pc_incr), .flags(flags), .mem_rdata(mem_rdata),
      .wb_req(wb_req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .mem_req(mem_req), .pc_req(pc_req), .fetch_ready(fetch_ready),
      .qphase(qphase));
   task automatic test_done;
      $display("Tests %0d, mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : test_done
   // One classic cycle; request stands until the edge that samples ack
   task automatic wb(input logic we, input logic [7:0] a,
      input logic [31:0] d);
      int i;
      @(posedge clk);
      wb_req <= '{1'b1, 1'b1, we, a, 4'hF, d};
      for (i = 0; i < 20; i++)
      begin
         // Pre-edge value: what the slave showed up to this edge
         @(posedge clk);
         if (wb_ack_o) break;
      end
      if (i == 20) begin bad_count++; test_done(); end
      rd = wb_dat_o;
      wb_req <= '0;
   endtask : wb
   // Present a word in Q1 of a ready cycle, then watch Q2 to Q4 and the next Q1
   task automatic issue(input logic [15:0] w, input logic [4:0] f,
      input logic [7:0] r);
      int i;
      for (i = 0; i < 20; i++)
      begin
         @(negedge clk);
         if (qphase == Q4 && fetch_ready) break;
      end
      if (i == 20) begin bad_count++; test_done(); end
      @(posedge clk);
      instr_valid <= 1'b1;
      instr <= w;
      flags <= f;
      mem_rdata <= r;
      @(posedge clk);
      instr_valid <= 1'b0;
      pw = 1'b0;
      mw = 1'b0;
      repeat (4)
      begin
         @(negedge clk);
         pw |= pc_req.wr;
         mw |= mem_req.wr;
      end
   endtask : issue
   task automatic br(input logic [15:0] w, input logic [4:0] f, input int n,
      input logic tk);
      issue(w, f, 8'h00);
      `CHK(pw, tk)
      if (tk) `CHK(pc_req.target, 21'(pc_incr + 2 * n))
   endtask : br
   task automatic set_file_bit(input logic [2:0] b, input logic a, input logic [7:0] f,
      input logic [11:0] ea, input logic [7:0] r);
      issue({OPC_SET_FILE_BIT, b, a, f}, 5'h1F, r);
      `CHK({mw, pw}, 2'b10)
      `CHK(mem_req.addr, ea)
      `CHK(mem_req.wdata, r | (8'h01 << b))
   endtask : set_file_bit
   // Main sequence: registers, bit set in every mode, then branches
   initial
   begin
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      wb(1'b1, OFS_BANK, 32'h0000_0005);
      wb(1'b0, OFS_BANK, 32'h0000_0000);
      `CHK(rd, 32'h0000_0005)
      wb(1'b0, 8'h20, 32'h0000_0000);
      `CHK(rd, 32'h0000_0000)
      // Clock enable low freezes the phase counter, then it runs on
      @(negedge clk);
      q0 = qphase;
      @(posedge clk);
      ce <= 1'b0;
      repeat (3) @(negedge clk);
      `CHK(qphase, q0 + 2'h1)
      @(posedge clk);
      ce <= 1'b1;
      @(posedge clk);
      @(negedge clk);
      `CHK(qphase, q0 + 2'h2)
      set_file_bit(3'h7, 1'b1, 8'h34, 12'h534, 8'h0A);
      set_file_bit(3'h0, 1'b0, 8'h10, 12'h010, 8'hF0);
      set_file_bit(3'h3, 1'b0, 8'h70, 12'hF70, 8'h08);
      wb(1'b1, OFS_IDXBASE, 32'h0000_0123);
      wb(1'b1, OFS_CTRL, 32'h0000_0001);
      wb(1'b0, OFS_IDXBASE, 32'h0000_0000);
      `CHK(rd, 32'h0000_0123)
      wb(1'b0, OFS_CTRL, 32'h0000_0000);
      `CHK(rd, 32'h0000_0001)
      set_file_bit(3'h5, 1'b0, 8'h5F, 12'h182, 8'h00);
      set_file_bit(3'h1, 1'b0, 8'h60, 12'hF60, 8'h00);
      set_file_bit(3'h2, 1'b1, 8'h5F, 12'h55F, 8'h00);
      br({OPC_BR_NO_OVERFLOW, 8'h80}, 5'h17, -128, 1'b1);
      br({OPC_BR_NO_OVERFLOW, 8'h7F}, 5'h08, 127, 1'b0);
      br({OPC_BR_NONZERO, 8'h7F}, 5'h08, 127, 1'b1);
      br({OPC_BR_NONZERO, 8'h80}, 5'h17, -128, 1'b0);
      br({OPC_BR_ALWAYS, 11'h400}, 5'h1F, -1024, 1'b1);
      br({OPC_BR_ALWAYS, 11'h3FF}, 5'h00, 1023, 1'b1);
      // Last taken target: 1000h plus twice 1023
      wb(1'b0, OFS_LASTPC, 32'h0000_0000);
      `CHK(rd, 32'h0000_17FE)
      test_done();
   end
endmodule : tb_branch_and_bit_set_exec
`default_nettype wire
